// *** rtl/iop_ports.sv ***
// Summary of operation
// - Eight analog-shared input pins, same every mode.
// - Input port reads live pins, no direction.
// - Two-pin bidirectional port, shares interrupts one, zero.
// - Pin one drives only in modes six, seven.
// - Pin zero direction bit selects input/output.
// - Two-pin direction loads E0, kept in standby.
// - Output pins keep driving in software standby.
// - Two-pin read: latch if output, else pin.
// - Two-pin data bits 7-5 read one.
// - Bits 4-2 stored; read latch or one.
// - Two-pin data loads E0, kept in standby.
// - Six-pin port shares serial and interrupt pins.
// - Six-pin direction bits 5-0 select output.
// - Six-pin direction register reads all ones.
// - Six-pin direction loads C0, kept in standby.
// - Six-pin read: latch if output, else pin.
// - Six-pin data bits 7-6 read one.
// - Six-pin data loads C0, kept in standby.
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.svh"

module iop_ports (
    input  wire logic                 ref_clk_i,                 // 40 MHz system clock
    input  wire logic                 rst_b_i,                   // Synchronous reset, active low
    input  wire logic [2:0]           mode_i,                    // Operating mode pins
    input  wire logic                 hw_standby_i,              // Hardware standby, active high
    input  wire logic                 sw_standby_i,              // Software standby, active high
    input  wire logic [17:0]          s_axi_awaddr_i,            // Write address
    input  wire logic                 s_axi_awvalid_i,           // Write address valid
    output logic                      s_axi_awready_o,           // Write address ready
    input  wire logic [31:0]          s_axi_wdata_i,             // Write data
    input  wire logic [3:0]           s_axi_wstrb_i,             // Write byte strobes
    input  wire logic                 s_axi_wvalid_i,            // Write data valid
    output logic                      s_axi_wready_o,            // Write data ready
    output logic [1:0]                s_axi_bresp_o,             // Write response
    output logic                      s_axi_bvalid_o,            // Write response valid
    input  wire logic                 s_axi_bready_i,            // Write response ready
    input  wire logic [17:0]          s_axi_araddr_i,            // Read address
    input  wire logic                 s_axi_arvalid_i,           // Read address valid
    output logic                      s_axi_arready_o,           // Read address ready
    output logic [31:0]               s_axi_rdata_o,             // Read data
    output logic [1:0]                s_axi_rresp_o,             // Read response
    output logic                      s_axi_rvalid_o,            // Read data valid
    input  wire logic                 s_axi_rready_i,            // Read data ready
    input  wire logic [7:0]           analog_pins_i,             // Input-only port pin levels
    input  wire logic [1:0]           p8_pin_i,                  // Two-pin port pin levels
    output iop_pkg::iop_p8_pad_s      p8_pad_o,                  // Two-pin port drive and enables
    input  wire logic [5:0]           p9_pin_i,                  // Six-pin port pin levels
    output iop_pkg::iop_p9_pad_s      p9_pad_o,                  // Six-pin port drive and enables
    output logic [7:0]                analog_level_o,            // Pin levels to the converter
    output logic                      external_interrupt_zero_o, // Interrupt zero pin level
    output logic                      external_interrupt_one_o,  // Interrupt one pin level
    output logic                      external_interrupt_four_o, // Interrupt four pin level
    output logic                      external_interrupt_five_o, // Interrupt five pin level
    output logic                      serial_zero_receive_o,     // Serial zero receive level
    output logic                      serial_one_receive_o,      // Serial one receive level
    output logic                      serial_zero_clock_pin_o,   // Serial zero clock pin level
    output logic                      serial_one_clock_pin_o     // Serial one clock pin level
);
    import iop_pkg::*;

    localparam int SYNC_W = 21;

    // Only the low bits are stored; the fixed upper ones are rebuilt on the read path.
    localparam logic [7:0] P8_RST_BYTE = `IOP_P8_RST;
    localparam logic [7:0] P9_RST_BYTE = `IOP_P9_RST;

    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_q;
    logic [7:0]        p7_lvl;
    logic [1:0]        p8_lvl;
    logic [5:0]        p9_lvl;
    logic [2:0]        mode_q;
    logic              hw_stby;
    logic              sw_stby;
    logic              clr;
    logic              pin1_drive_ok;

    logic [4:0]        p8_ddr;
    logic [4:0]        p8_dr;
    logic [5:0]        p9_ddr;
    logic [5:0]        p9_dr;

    iop_wr_e           wr_state;
    iop_rd_e           rd_state;
    logic              aw_got;
    logic              w_got;
    logic [15:0]       wr_idx;
    logic [7:0]        wr_byte;
    logic              wr_lane0;
    logic              wr_fire;
    logic [15:0]       rd_idx;
    logic [7:0]        next_rbyte;
    logic              next_rmapped;
    logic              next_wmapped;

    // Every pin, strap and standby level crosses in through two flops.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            sync_meta <= '0;
            sync_q    <= '0;
        end
        else
        begin
            sync_meta <= {sw_standby_i, hw_standby_i, mode_i, p9_pin_i, p8_pin_i, analog_pins_i};
            sync_q    <= sync_meta;
        end
    end

    assign p7_lvl  = sync_q[7:0];
    assign p8_lvl  = sync_q[9:8];
    assign p9_lvl  = sync_q[15:10];
    assign mode_q  = sync_q[18:16];
    assign hw_stby = sync_q[19];
    assign sw_stby = sync_q[20];

    // Hardware standby initialises exactly as reset does; software standby changes nothing here.
    assign clr = !rst_b_i || hw_stby;
    assign pin1_drive_ok = (mode_q == `IOP_MODE_SIX) || (mode_q == `IOP_MODE_SEVEN);

    // Shared pin levels go to the converter, interrupt and serial logic in every mode.
    assign analog_level_o            = p7_lvl;
    assign external_interrupt_zero_o = sync_q[8];
    assign external_interrupt_one_o  = sync_q[9];
    assign serial_zero_receive_o     = sync_q[12];
    assign serial_one_receive_o      = sync_q[13];
    assign serial_zero_clock_pin_o   = sync_q[14];
    assign external_interrupt_four_o = sync_q[14];
    assign serial_one_clock_pin_o    = sync_q[15];
    assign external_interrupt_five_o = sync_q[15];

    assign wr_fire  = (wr_state == IOP_WR_IDLE) && aw_got && w_got;

    // Write channel: address and data are taken in either order, the answer follows both.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            wr_state        <= IOP_WR_IDLE;
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            wr_idx          <= 16'h0000;
            wr_byte         <= 8'h00;
            wr_lane0        <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= `IOP_RESP_OKAY;
        end
        else
        begin
            unique case (wr_state)
                IOP_WR_IDLE:
                begin
                    if (s_axi_awvalid_i && s_axi_awready_o)
                    begin
                        aw_got <= 1'b1;
                        wr_idx <= s_axi_awaddr_i[17:2];
                    end
                    if (s_axi_wvalid_i && s_axi_wready_o)
                    begin
                        w_got    <= 1'b1;
                        wr_byte  <= s_axi_wdata_i[7:0];
                        wr_lane0 <= s_axi_wstrb_i[0];
                    end
                    s_axi_awready_o <= !aw_got && !(s_axi_awvalid_i && s_axi_awready_o);
                    s_axi_wready_o  <= !w_got && !(s_axi_wvalid_i && s_axi_wready_o);
                    if (wr_fire)
                    begin
                        wr_state        <= IOP_WR_RESP;
                        s_axi_bvalid_o  <= 1'b1;
                        s_axi_bresp_o   <= next_wmapped ? `IOP_RESP_OKAY : `IOP_RESP_DECERR;
                        s_axi_awready_o <= 1'b0;
                        s_axi_wready_o  <= 1'b0;
                    end
                end
                IOP_WR_RESP:
                begin
                    if (s_axi_bready_i)
                    begin
                        wr_state        <= IOP_WR_IDLE;
                        s_axi_bvalid_o  <= 1'b0;
                        aw_got          <= 1'b0;
                        w_got           <= 1'b0;
                        s_axi_awready_o <= 1'b1;
                        s_axi_wready_o  <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_comb
    begin
        unique case (wr_idx)
            `IOP_IDX_P8_DIR,
            `IOP_IDX_P7_IN,
            `IOP_IDX_P8_DATA,
            `IOP_IDX_P9_DIR,
            `IOP_IDX_P9_DATA: next_wmapped = 1'b1;
            default:          next_wmapped = 1'b0;
        endcase
    end

    // Two-pin port direction; bits 7 to 5 are fixed ones and are not stored.
    always_ff @(posedge ref_clk_i)
    begin
        if (clr)
            p8_ddr <= P8_RST_BYTE[`IOP_P8_STORE_MSB:0];
        else if (wr_fire && wr_lane0 && wr_idx == `IOP_IDX_P8_DIR)
            p8_ddr <= wr_byte[`IOP_P8_STORE_MSB:0];
    end

    // Two-pin port data; bits 4 to 2 are plain storage with no pin behind them.
    always_ff @(posedge ref_clk_i)
    begin
        if (clr)
            p8_dr <= P8_RST_BYTE[`IOP_P8_STORE_MSB:0];
        else if (wr_fire && wr_lane0 && wr_idx == `IOP_IDX_P8_DATA)
            p8_dr <= wr_byte[`IOP_P8_STORE_MSB:0];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (clr)
            p9_ddr <= P9_RST_BYTE[`IOP_P9_PIN_MSB:0];
        else if (wr_fire && wr_lane0 && wr_idx == `IOP_IDX_P9_DIR)
            p9_ddr <= wr_byte[`IOP_P9_PIN_MSB:0];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (clr)
            p9_dr <= P9_RST_BYTE[`IOP_P9_PIN_MSB:0];
        else if (wr_fire && wr_lane0 && wr_idx == `IOP_IDX_P9_DATA)
            p9_dr <= wr_byte[`IOP_P9_PIN_MSB:0];
    end

    // Pad drive ignores software standby on purpose so that outputs hold their level.
    // Pin one is never enabled in modes one, three and five even if software sets its bit.
    always_ff @(posedge ref_clk_i)
    begin
        if (clr)
        begin
            p8_pad_o <= '0;
            p9_pad_o <= '0;
        end
        else
        begin
            p8_pad_o.dout <= p8_dr[`IOP_P8_PIN_MSB:0];
            p8_pad_o.oe   <= {p8_ddr[1] && pin1_drive_ok, p8_ddr[0]};
            p9_pad_o.dout <= p9_dr;
            p9_pad_o.oe   <= p9_ddr;
        end
    end

    // Read multiplexer: latch for output pins, synchronised pin level for inputs.
    always_comb
    begin
        next_rbyte   = 8'hFF;
        next_rmapped = 1'b1;
        unique case (s_axi_araddr_i[17:2])
            `IOP_IDX_P7_IN:   next_rbyte = p7_lvl;
            `IOP_IDX_P8_DIR:  next_rbyte = 8'hFF;
            `IOP_IDX_P9_DIR:  next_rbyte = 8'hFF;
            `IOP_IDX_P8_DATA:
                next_rbyte = {3'b111,
                              p8_dr[4:2] | ~p8_ddr[4:2],
                              (p8_ddr[1:0] & p8_dr[1:0]) | (~p8_ddr[1:0] & p8_lvl)};
            `IOP_IDX_P9_DATA:
                next_rbyte = {2'b11, (p9_ddr & p9_dr) | (~p9_ddr & p9_lvl)};
            default:          next_rmapped = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            rd_state        <= IOP_RD_IDLE;
            rd_idx          <= 16'h0000;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h00000000;
            s_axi_rresp_o   <= `IOP_RESP_OKAY;
        end
        else
        begin
            unique case (rd_state)
                IOP_RD_IDLE:
                begin
                    s_axi_arready_o <= 1'b1;
                    if (s_axi_arvalid_i && s_axi_arready_o)
                    begin
                        rd_state        <= IOP_RD_DATA;
                        rd_idx          <= s_axi_araddr_i[17:2];
                        s_axi_arready_o <= 1'b0;
                        s_axi_rvalid_o  <= 1'b1;
                        s_axi_rdata_o   <= next_rmapped ? {24'h000000, next_rbyte} : 32'h00000000;
                        s_axi_rresp_o   <= next_rmapped ? `IOP_RESP_OKAY : `IOP_RESP_DECERR;
                    end
                end
                IOP_RD_DATA:
                begin
                    if (s_axi_rready_i)
                    begin
                        rd_state        <= IOP_RD_IDLE;
                        s_axi_rvalid_o  <= 1'b0;
                        s_axi_arready_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    chk_p7_read_live: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(s_axi_rvalid_o) && rd_idx == `IOP_IDX_P7_IN |-> s_axi_rdata_o[7:0] == $past(p7_lvl))
        else $error("input port read does not show pin levels");

    chk_p8_pin1_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        p8_pad_o.oe[1] |-> $past(pin1_drive_ok))
        else $error("pin one driven outside modes six and seven");

    chk_p8_pin0_dir: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        p8_ddr[0] && !hw_stby ##1 rst_b_i |-> p8_pad_o.oe[0] && p8_pad_o.dout[0] == $past(p8_dr[0]))
        else $error("pin zero does not follow its direction bit");

    chk_p8_dir_init: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        hw_stby |=> p8_ddr == 5'h00 && p8_dr == 5'h00 && p8_pad_o.oe == 2'b00)
        else $error("two-pin port not initialised by hardware standby");

    chk_sw_stby_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sw_stby && !hw_stby && !wr_fire |=> $stable(p9_dr) && $stable(p8_dr) && $stable(p9_ddr))
        else $error("port state changed in software standby");

    chk_p8_read_mux: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(s_axi_rvalid_o) && rd_idx == `IOP_IDX_P8_DATA && $past(p8_ddr[1:0] == 2'b00)
        |-> s_axi_rdata_o[7:0] == {3'b111, $past(p8_dr[4:2] | ~p8_ddr[4:2]), $past(p8_lvl)})
        else $error("two-pin read does not show pin levels for inputs");

    chk_p8_spare_ones: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(s_axi_rvalid_o) && rd_idx == `IOP_IDX_P8_DATA && $past(p8_ddr[4:2] == 3'b000)
        |-> s_axi_rdata_o[7:2] == 6'h3F)
        else $error("spare bits do not read as one");

    chk_dir_read_ones: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(s_axi_rvalid_o) && (rd_idx == `IOP_IDX_P9_DIR || rd_idx == `IOP_IDX_P8_DIR)
        |-> s_axi_rdata_o == 32'h000000FF && s_axi_rresp_o == `IOP_RESP_OKAY)
        else $error("direction register read is not all ones");

    chk_p9_read_mux: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(s_axi_rvalid_o) && rd_idx == `IOP_IDX_P9_DATA
        |-> s_axi_rdata_o[7:0] == {2'b11, $past((p9_ddr & p9_dr) | (~p9_ddr & p9_lvl))})
        else $error("six-pin read mixes latch and pin wrongly");

    chk_p9_data_init: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        hw_stby ##1 hw_stby |-> p9_dr == 6'h00 && p9_ddr == 6'h00 && p9_pad_o.oe == 6'h00)
        else $error("six-pin port not initialised by hardware standby");

    chk_p9_pad_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !hw_stby |=> p9_pad_o.oe == $past(p9_ddr) && p9_pad_o.dout == $past(p9_dr))
        else $error("six-pin pads do not follow direction and data");

    chk_p8_upper_ones: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(s_axi_rvalid_o) && rd_idx == `IOP_IDX_P8_DATA |-> s_axi_rdata_o[7:5] == 3'b111)
        else $error("two-pin data upper bits do not read as one");

    chk_p9_upper_ones: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(s_axi_rvalid_o) && rd_idx == `IOP_IDX_P9_DATA |-> s_axi_rdata_o[7:6] == 2'b11)
        else $error("six-pin data reserved bits do not read as one");

endmodule : iop_ports
`default_nettype wire

// *** inc/iop_defs.svh ***
`ifndef IOP_DEFS_SVH
`define IOP_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IOP_IDX_P8_DIR      16'hFFCD
`define IOP_IDX_P7_IN       16'hFFCE
`define IOP_IDX_P8_DATA     16'hFFCF
`define IOP_IDX_P9_DIR      16'hFFD0
`define IOP_IDX_P9_DATA     16'hFFD2

// Reset and hardware-standby values of the stored registers.
`define IOP_P8_RST          8'hE0
`define IOP_P9_RST          8'hC0

// Field positions.
`define IOP_P8_STORE_MSB    4
`define IOP_P8_PIN_MSB      1
`define IOP_P9_PIN_MSB      5
`define IOP_P8_SPARE_LSB    2

// Operating modes in which the upper two-pin port pin may drive.
`define IOP_MODE_SIX        3'h6
`define IOP_MODE_SEVEN      3'h7

// Bus answers.
`define IOP_RESP_OKAY       2'h0
`define IOP_RESP_DECERR     2'h3

`endif

// *** inc/iop_pkg.sv ***
package iop_pkg;

    typedef enum logic [1:0] {
        IOP_WR_IDLE = 2'b01,
        IOP_WR_RESP = 2'b10
    } iop_wr_e;

    typedef enum logic [1:0] {
        IOP_RD_IDLE = 2'b01,
        IOP_RD_DATA = 2'b10
    } iop_rd_e;

    typedef struct packed {
        logic [1:0] dout;
        logic [1:0] oe;
    } iop_p8_pad_s;

    typedef struct packed {
        logic [5:0] dout;
        logic [5:0] oe;
    } iop_p9_pad_s;

endpackage : iop_pkg

// *** sim/iop_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module iop_pin_model (
    input  wire logic [1:0]          ext_p8_i, // Outside level, two-pin port
    input  wire logic [5:0]          ext_p9_i, // Outside level, six-pin port
    input  wire iop_pkg::iop_p8_pad_s p8_pad_i, // Device drive, two-pin port
    input  wire iop_pkg::iop_p9_pad_s p9_pad_i, // Device drive, six-pin port
    output logic [1:0]               p8_pin_o, // Resolved two-pin levels
    output logic [5:0]               p9_pin_o  // Resolved six-pin levels
);
    import iop_pkg::*;

    // Outside drivers are taken as weak, so a pin that the device enables shows its level.
    assign p8_pin_o = (p8_pad_i.oe & p8_pad_i.dout) | (~p8_pad_i.oe & ext_p8_i);
    assign p9_pin_o = (p9_pad_i.oe & p9_pad_i.dout) | (~p9_pad_i.oe & ext_p9_i);

endmodule : iop_pin_model

`default_nettype wire

// *** sim/tb_input_output_ports_seven_to_nine.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.svh"

module tb_input_output_ports_seven_to_nine;
    import iop_pkg::*;

    logic        clk, rst_b, hw_sb, sw_sb;
    logic [2:0]  mode;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, ext_p8, p8_pin;
    logic [5:0]  ext_p9, p9_pin;
    logic [7:0]  analog, analog_lvl;
    logic        external_interrupt_zero, external_interrupt_one, external_interrupt_four, external_interrupt_five, srx0, srx1, serial_zero_clock_pin, serial_one_clock_pin;
    iop_p8_pad_s p8_pad;
    iop_p9_pad_s p9_pad;
    int          miscompares, tests_run;

    iop_ports dut (
        .ref_clk_i(clk), .rst_b_i(rst_b), .mode_i(mode), .hw_standby_i(hw_sb), .sw_standby_i(sw_sb),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .analog_pins_i(analog), .p8_pin_i(p8_pin), .p8_pad_o(p8_pad), .p9_pin_i(p9_pin), .p9_pad_o(p9_pad),
        .analog_level_o(analog_lvl), .external_interrupt_zero_o(external_interrupt_zero), .external_interrupt_one_o(external_interrupt_one),
        .external_interrupt_four_o(external_interrupt_four), .external_interrupt_five_o(external_interrupt_five),
        .serial_zero_receive_o(srx0), .serial_one_receive_o(srx1),
        .serial_zero_clock_pin_o(serial_zero_clock_pin), .serial_one_clock_pin_o(serial_one_clock_pin)
    );

    iop_pin_model pins (
        .ext_p8_i(ext_p8), .ext_p9_i(ext_p9), .p8_pad_i(p8_pad), .p9_pad_i(p9_pad),
        .p8_pin_o(p8_pin), .p9_pin_o(p9_pin)
    );

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stuck;
        miscompares++;
        $display("CHECK FAILED at %0t: bus handshake timed out", $time);
        end_sim();
    endtask : stuck

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Address and data are offered together and each is dropped at the edge that takes it.
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50 && !(bvalid && bready); n++)
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (!(bvalid && bready)) stuck();
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        // One idle edge keeps the next call from re-raising bready in this time step.
        tick(1);
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er);
        int n;
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50 && !(rvalid && rready); n++)
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (!(rvalid && rready)) stuck();
        rready <= 1'b0;
        chk(rdata, {24'h0, exp});
        chk({30'h0, rresp}, {30'h0, er});
        tick(1);
    endtask : rd

    task automatic test_reset_state;
        chk({24'h0, p9_pad.oe, p8_pad.oe}, 32'h0);
        rd(`IOP_IDX_P8_DIR, 8'hFF, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P9_DIR, 8'hFF, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P8_DATA, 8'hFE, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P9_DATA, 8'hEA, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P7_IN, 8'h5A, `IOP_RESP_OKAY);
        chk({24'h0, analog_lvl}, 32'h5A);
        chk({28'h0, external_interrupt_five, external_interrupt_four, external_interrupt_one, external_interrupt_zero}, 32'hA);
        chk({28'h0, serial_one_clock_pin, serial_zero_clock_pin, srx1, srx0}, 32'hA);
        $display("test reset_state done");
    endtask : test_reset_state

    task automatic test_six_pin;
        wr(`IOP_IDX_P9_DIR, 8'h0F, `IOP_RESP_OKAY);
        wr(`IOP_IDX_P9_DATA, 8'h35, `IOP_RESP_OKAY);
        wr(`IOP_IDX_P7_IN, 8'h00, `IOP_RESP_OKAY);
        ext_p9 <= 6'h00;
        analog <= 8'hA5;
        tick(4);
        chk({26'h0, p9_pad.oe}, 32'h0F);
        chk({28'h0, p9_pad.dout[3:0]}, 32'h5);
        rd(`IOP_IDX_P9_DATA, 8'hC5, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P7_IN, 8'hA5, `IOP_RESP_OKAY);
        wr(`IOP_IDX_P9_DATA, 8'h0A, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P9_DATA, 8'hCA, `IOP_RESP_OKAY);
        wstrb <= 4'hE;
        wr(`IOP_IDX_P9_DATA, 8'h3F, `IOP_RESP_OKAY);
        wstrb <= 4'hF;
        rd(`IOP_IDX_P9_DATA, 8'hCA, `IOP_RESP_OKAY);
        wr(16'hFFD1, 8'hFF, `IOP_RESP_DECERR);
        rd(16'hFFD1, 8'h00, `IOP_RESP_DECERR);
        $display("test six_pin done");
    endtask : test_six_pin

    task automatic test_two_pin_modes;
        logic [2:0] modes [5] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
        mode <= 3'h1;
        ext_p8 <= 2'b00;
        tick(4);
        wr(`IOP_IDX_P8_DIR, 8'h1D, `IOP_RESP_OKAY);
        wr(`IOP_IDX_P8_DATA, 8'h0B, `IOP_RESP_OKAY);
        tick(4);
        rd(`IOP_IDX_P8_DATA, 8'hE9, `IOP_RESP_OKAY);
        // Pin one is given a direction bit only in the modes that let it drive.
        foreach (modes[i])
        begin
            mode <= modes[i];
            tick(4);
            wr(`IOP_IDX_P8_DIR, (modes[i] >= 3'h6) ? 8'h03 : 8'h01, `IOP_RESP_OKAY);
            tick(2);
            chk({30'h0, p8_pad.oe}, (modes[i] >= 3'h6) ? 32'h3 : 32'h1);
        end
        chk({30'h0, p8_pad.dout}, 32'h3);
        rd(`IOP_IDX_P8_DATA, 8'hFF, `IOP_RESP_OKAY);
        $display("test two_pin_modes done");
    endtask : test_two_pin_modes

    task automatic test_standby;
        sw_sb <= 1'b1;
        tick(6);
        chk({28'h0, p8_pad.oe, p8_pad.dout}, 32'hF);
        chk({22'h0, p9_pad.oe, p9_pad.dout[3:0]}, 32'h0FA);
        rd(`IOP_IDX_P9_DATA, 8'hCA, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P8_DATA, 8'hFF, `IOP_RESP_OKAY);
        sw_sb <= 1'b0;
        hw_sb <= 1'b1;
        tick(5);
        chk({24'h0, p9_pad.oe, p8_pad.oe}, 32'h0);
        hw_sb <= 1'b0;
        tick(4);
        rd(`IOP_IDX_P8_DATA, 8'hFC, `IOP_RESP_OKAY);
        wr(`IOP_IDX_P8_DIR, 8'h1D, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P8_DATA, 8'hE0, `IOP_RESP_OKAY);
        wr(`IOP_IDX_P9_DIR, 8'h3F, `IOP_RESP_OKAY);
        rd(`IOP_IDX_P9_DATA, 8'hC0, `IOP_RESP_OKAY);
        $display("test standby done");
    endtask : test_standby

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        {rst_b, hw_sb, sw_sb, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb  = 4'hF;
        mode   = 3'h6;
        ext_p8 = 2'b10;
        ext_p9 = 6'h2A;
        analog = 8'h5A;
        miscompares = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        tick(3);
        test_reset_state();
        test_six_pin();
        test_two_pin_modes();
        test_standby();
        end_sim();
    end

endmodule : tb_input_output_ports_seven_to_nine

`default_nettype wire
